// *** logic/tec_pkg.sv ***
package tec_pkg;

  // register indices on the special function register port
  localparam logic [1:0] TEC_IDX_CTRL   = 2'h0;
  localparam logic [1:0] TEC_IDX_CNT_LO = 2'h1;
  localparam logic [1:0] TEC_IDX_CNT_HI = 2'h2;

  // counter_mode_control field positions
  localparam int TEC_POS_MODE_HI = 7;
  localparam int TEC_POS_MODE_LO = 6;
  localparam int TEC_POS_SRC     = 5;
  localparam int TEC_POS_RUN     = 4;
  localparam int TEC_POS_EDGE    = 3;
  localparam int TEC_POS_PSC_HI  = 2;
  localparam int TEC_POS_PSC_LO  = 0;

  localparam logic [7:0] TEC_CTRL_RST   = 8'h00;
  // bit 5 exists only in the wide counter
  localparam logic [7:0] TEC_CTRL_MASK8 = 8'hdf;
  localparam logic [7:0] TEC_CTRL_MASKW = 8'hff;

  // mode_select_pair codes
  localparam logic [1:0] TEC_MODE_OFF   = 2'h0;
  localparam logic [1:0] TEC_MODE_EVENT = 2'h1;
  localparam logic [1:0] TEC_MODE_TIMER = 2'h2;
  localparam logic [1:0] TEC_MODE_PULSE = 2'h3;

  localparam int         TEC_PSC_W        = 3;
  localparam int         TEC_PSC_STAGES   = 7;
  localparam logic [2:0] TEC_SYS_DIV4_EXP = 3'h2;

  localparam logic [15:0] TEC_PRELOAD_RST = 16'h0000;
  localparam logic [15:0] TEC_COUNT_RST   = 16'h0000;
  localparam logic [15:0] TEC_FULL8       = 16'h00ff;
  localparam logic [15:0] TEC_FULL16      = 16'hffff;
  localparam logic [7:0]  TEC_BYTE_ZERO   = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] idx;
    logic [7:0] wdata;
  } tec_sfr_req_t;

  typedef enum logic [2:0] {
    TEC_PW_IDLE  = 3'b001,
    TEC_PW_ARMED = 3'b010,
    TEC_PW_COUNT = 3'b100
  } tec_pw_state_t;

  typedef struct packed {
    logic [7:0]    ctrl;
    logic [15:0]   preload;
    logic [15:0]   count;
    logic [7:0]    lbuf;
    tec_pw_state_t pw;
    logic [7:0]    rdata;
    logic          ovf;
    logic          irq;
    logic          wake;
  } tec_core_st_t;

  typedef struct packed {
    logic [TEC_PSC_STAGES-1:0] div;
    logic                      tick;
  } tec_psc_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic last;
    logic rise;
    logic fall;
  } tec_sync_st_t;

endpackage : tec_pkg

// *** logic/tec_prescaler.sv ***
`timescale 1ns/10ps
module tec_prescaler
  import tec_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire logic [TEC_PSC_W-1:0] rate,
  output logic                      tick
);

  tec_psc_st_t               st_r;
  tec_psc_st_t               st_nxt;
  logic [TEC_PSC_STAGES:0]   mask;

  // divide by two to the power of rate; rate 0 ticks every cycle
  assign mask = (TEC_PSC_STAGES+1)'((8'h01 << rate) - 8'h01);

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.div  = TEC_PSC_STAGES'(st_r.div + 1'b1);
    st_nxt.tick = (st_r.div & mask[TEC_PSC_STAGES-1:0]) ==
                  mask[TEC_PSC_STAGES-1:0];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign tick = st_r.tick;

endmodule : tec_prescaler

// *** logic/tec_pin_sync.sv ***
`timescale 1ns/10ps
module tec_pin_sync
  import tec_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  tec_sync_st_t st_r;
  tec_sync_st_t st_nxt;

  // s1 is read by s2 alone, edges come from the settled stages
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.s1   = pin_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.last = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.last;
    st_nxt.fall = ~st_r.s2 & st_r.last;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule : tec_pin_sync

// *** logic/tec_timer_event_counter.sv ***
`timescale 1ns/10ps
module tec_timer_event_counter
  import tec_pkg::*;
#(
  parameter bit WIDE = 1'b0
)
(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire tec_sfr_req_t sfr_req,
  output logic [7:0]        sfr_rdata,
  input  wire logic         tmr_pin,
  input  wire logic         sub_clk,
  input  wire logic         pdn,
  input  wire logic         int_en,
  output logic              ovf_pulse,
  output logic              irq_req,
  output logic              wake_req
);

  tec_core_st_t        st_r;
  tec_core_st_t        st_nxt;
  logic [1:0]          mode_select_pair;
  logic                run_enable_bit;
  logic                active_edge_select;
  logic                wide_clock_source_select;
  logic [TEC_PSC_W-1:0] prescale_rate_field;
  logic [TEC_PSC_W-1:0] psc_rate;
  logic                psc_tick;
  logic                sub_rise;
  logic                pin_rise;
  logic                pin_fall;
  logic                int_tick;
  logic                evt_edge;
  logic                pw_start;
  logic                pw_ret;
  logic                pulse_armed;
  logic                inc;
  logic                full;
  logic [15:0]         full_val;
  logic                wr_ctrl;
  logic                wr_lo;
  logic                wr_hi;
  logic                rd_lo;
  logic                rd_hi;
  logic                pre_wr;
  logic [15:0]         new_pre;

  assign mode_select_pair         =
    st_r.ctrl[TEC_POS_MODE_HI:TEC_POS_MODE_LO];
  assign run_enable_bit           = st_r.ctrl[TEC_POS_RUN];
  assign active_edge_select       = st_r.ctrl[TEC_POS_EDGE];
  assign wide_clock_source_select = st_r.ctrl[TEC_POS_SRC];
  assign prescale_rate_field      = st_r.ctrl[TEC_POS_PSC_HI:TEC_POS_PSC_LO];

  // the wide counter reuses the prescaler as a fixed divide by four
  assign psc_rate = WIDE ? TEC_SYS_DIV4_EXP : prescale_rate_field;

  tec_prescaler u_prescaler
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .rate    (psc_rate),
    .tick    (psc_tick)
  );

  tec_pin_sync u_pin_sync
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .pin_in  (tmr_pin),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // sub clock is sampled, so it must stay well below clk_sys / 2
  tec_pin_sync u_sub_sync
  (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .pin_in  (sub_clk),
    .rise    (sub_rise),
    .fall    ()
  );

  // source select high picks system clock over four
  assign int_tick = (WIDE && !wide_clock_source_select) ? sub_rise
                                                        : psc_tick;
  assign evt_edge = active_edge_select ? pin_fall : pin_rise;
  assign pw_start = active_edge_select ? pin_rise : pin_fall;
  assign pw_ret   = evt_edge;
  assign pulse_armed = (mode_select_pair == TEC_MODE_PULSE) && run_enable_bit;

  always_comb
  begin
    unique case (mode_select_pair)
      TEC_MODE_TIMER:
        inc = run_enable_bit & int_tick & ~pdn;
      TEC_MODE_EVENT:
        inc = run_enable_bit & evt_edge;
      TEC_MODE_PULSE:
        inc = pulse_armed & (st_r.pw == TEC_PW_COUNT) & int_tick & ~pdn;
      TEC_MODE_OFF:
        inc = 1'b0;
    endcase
  end

  assign full_val = WIDE ? TEC_FULL16 : TEC_FULL8;
  assign full     = st_r.count == full_val;

  assign wr_ctrl = sfr_req.wr && sfr_req.idx == TEC_IDX_CTRL;
  assign wr_lo   = sfr_req.wr && sfr_req.idx == TEC_IDX_CNT_LO;
  assign wr_hi   = sfr_req.wr && sfr_req.idx == TEC_IDX_CNT_HI && WIDE;
  assign rd_lo   = sfr_req.rd && sfr_req.idx == TEC_IDX_CNT_LO;
  assign rd_hi   = sfr_req.rd && sfr_req.idx == TEC_IDX_CNT_HI && WIDE;
  // the wide preload only moves on the high byte, so low must go first
  assign pre_wr  = WIDE ? wr_hi : wr_lo;
  assign new_pre = WIDE ? {sfr_req.wdata, st_r.lbuf}
                        : {TEC_BYTE_ZERO, sfr_req.wdata};

  always_comb
  begin
    st_nxt = st_r;

    // counting and automatic reload
    if (inc)
    begin
      if (full)
        st_nxt.count = st_r.preload;
      else
        st_nxt.count = 16'(st_r.count + 16'h0001);
    end
    st_nxt.ovf  = inc & full;
    st_nxt.irq  = inc & full & int_en;
    st_nxt.wake = inc & full & pdn &
                  (mode_select_pair == TEC_MODE_EVENT);

    // single shot pulse measurement
    unique case (st_r.pw)
      TEC_PW_IDLE:
        if (pulse_armed)
          st_nxt.pw = TEC_PW_ARMED;
      TEC_PW_ARMED:
        if (!pulse_armed)
          st_nxt.pw = TEC_PW_IDLE;
        else if (pw_start)
          st_nxt.pw = TEC_PW_COUNT;
      TEC_PW_COUNT:
        if (!pulse_armed)
          st_nxt.pw = TEC_PW_IDLE;
        else if (pw_ret)
        begin
          st_nxt.pw                = TEC_PW_IDLE;
          st_nxt.ctrl[TEC_POS_RUN] = 1'b0;
        end
      default:
        st_nxt.pw = TEC_PW_IDLE;
    endcase

    // software write after the auto clear, so software wins a tie
    if (wr_ctrl)
      st_nxt.ctrl = sfr_req.wdata & (WIDE ? TEC_CTRL_MASKW : TEC_CTRL_MASK8);

    if (WIDE && wr_lo)
      st_nxt.lbuf = sfr_req.wdata;
    if (pre_wr)
    begin
      st_nxt.preload = new_pre;
      if (!run_enable_bit)
        st_nxt.count = new_pre;
    end

    // reads: registered data, one cycle after the strobe
    if (sfr_req.rd)
    begin
      unique case (sfr_req.idx)
        TEC_IDX_CTRL:
          st_nxt.rdata = st_r.ctrl;
        TEC_IDX_CNT_LO:
          st_nxt.rdata = WIDE ? st_r.lbuf : st_r.count[7:0];
        TEC_IDX_CNT_HI:
          st_nxt.rdata = WIDE ? st_r.count[15:8] : TEC_BYTE_ZERO;
        default:
          st_nxt.rdata = TEC_BYTE_ZERO;
      endcase
    end
    if (rd_hi)
      st_nxt.lbuf = st_r.count[7:0];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r         <= '0;
      st_r.ctrl    <= TEC_CTRL_RST;
      // preload resets to zero, so each reload restarts from zero until software loads it
      st_r.preload <= TEC_PRELOAD_RST;
      st_r.count   <= TEC_COUNT_RST;
      st_r.pw      <= TEC_PW_IDLE;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign sfr_rdata = st_r.rdata;
  assign ovf_pulse = st_r.ovf;
  assign irq_req   = st_r.irq;
  assign wake_req  = st_r.wake;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_inc_one;
    ce && inc && !full |=> st_r.count == 16'($past(st_r.count) + 16'h0001);
  endproperty
  a_inc_one: assert property (p_inc_one)
    else $error("counter did not add one");

  property p_ovf_irq;
    ce && inc && full |=> ovf_pulse && (irq_req == $past(int_en));
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow or interrupt request wrong");

  property p_irq_masked;
    ce && inc && full && !int_en |=> ovf_pulse && !irq_req;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked overflow raised interrupt request");

  property p_reload;
    ce && inc && full |=> st_r.count == $past(st_r.preload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded from preload");

  property p_stopped_copy;
    ce && pre_wr && !run_enable_bit |=>
      st_r.count == $past(new_pre) && st_r.preload == $past(new_pre);
  endproperty
  a_stopped_copy: assert property (p_stopped_copy)
    else $error("stopped preload write not copied");

  property p_running_hold;
    ce && pre_wr && run_enable_bit && !inc |=>
      st_r.count == $past(st_r.count) && st_r.preload == $past(new_pre);
  endproperty
  a_running_hold: assert property (p_running_hold)
    else $error("running preload write touched counter");

  property p_low_buffer;
    WIDE && ce && wr_lo && !inc |=>
      st_r.count == $past(st_r.count) && st_r.lbuf == $past(sfr_req.wdata);
  endproperty
  a_low_buffer: assert property (p_low_buffer)
    else $error("low byte write reached counter");

  property p_high_latch;
    WIDE && ce && rd_hi |=> st_r.lbuf == $past(st_r.count[7:0]);
  endproperty
  a_high_latch: assert property (p_high_latch)
    else $error("high read did not latch low byte");

  property p_low_read;
    WIDE && ce && rd_lo |=> sfr_rdata == $past(st_r.lbuf);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low read did not return buffer");

  property p_hold_off;
    ce && !run_enable_bit && !pre_wr |=> st_r.count == $past(st_r.count);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("counter moved while stopped");

  property p_wake;
    ce && inc && full && pdn && mode_select_pair == TEC_MODE_EVENT
      |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("power-down overflow gave no wake");

  sequence s_pw_begin;
    ce && st_r.pw == TEC_PW_ARMED && pulse_armed && pw_start;
  endsequence

  sequence s_pw_end;
    ce && st_r.pw == TEC_PW_COUNT && pulse_armed && pw_ret && !wr_ctrl;
  endsequence

  property p_pw_arm;
    s_pw_begin |=> st_r.pw == TEC_PW_COUNT;
  endproperty
  a_pw_arm: assert property (p_pw_arm)
    else $error("active edge did not start measurement");

  property p_pw_stop;
    s_pw_end |=> !run_enable_bit && st_r.pw == TEC_PW_IDLE ##1
      !run_enable_bit || !ce || $past(wr_ctrl);
  endproperty
  a_pw_stop: assert property (p_pw_stop)
    else $error("pin return did not clear run");

  property p_armed_quiet;
    st_r.pw == TEC_PW_ARMED && mode_select_pair == TEC_MODE_PULSE |-> !inc;
  endproperty
  a_armed_quiet: assert property (p_armed_quiet)
    else $error("counted before active edge");

endmodule : tec_timer_event_counter

// *** verification/tec_pin_model.sv ***
`timescale 1ns/10ps
module tec_pin_model
(
  input  wire logic clk_sys,
  output logic      tmr_pin,
  output logic      sub_clk
);

  // slow clock of 32 system periods, offset so it never meets a system edge
  initial
  begin
    sub_clk = 1'b0;
    #7;
    forever #400 sub_clk = ~sub_clk;
  end

  initial tmr_pin = 1'b0;

  // gap lets the pin settle through the synchroniser before the next edge
  task automatic toggle(input int n, input int gap);
    repeat (n)
    begin
      @(posedge clk_sys);
      tmr_pin <= ~tmr_pin;
      repeat (gap) @(posedge clk_sys);
    end
  endtask : toggle

endmodule : tec_pin_model

// *** verification/tb_tec_timer_event_counter.sv ***
`timescale 1ns/10ps
module tb_tec_timer_event_counter
  import tec_pkg::*;
;
  logic         clk_sys    = 1'b0;
  logic         arst_n     = 1'b0;
  logic         ce         = 1'b1;
  tec_sfr_req_t sfr_req    = '0;
  logic [7:0]   sfr_rdata;
  logic         tmr_pin;
  logic         sub_clk;
  logic         pdn        = 1'b0;
  logic         int_en     = 1'b0;
  logic         ovf_pulse;
  logic         irq_req;
  logic         wake_req;
  int           mismatches = 0;
  int           n_compared = 0;
  int           cyc        = 0;
  int           g;
  logic [15:0]  v;
  logic [15:0]  w;
  logic [7:0]   b;

  always #12.5 clk_sys = ~clk_sys;

  // the wide counter carries the byte-buffer logic, so it is the one tested
  tec_timer_event_counter #(.WIDE(1'b1)) tec_timer_event_counter_i (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .ce        (ce),
    .sfr_req   (sfr_req),
    .sfr_rdata (sfr_rdata),
    .tmr_pin   (tmr_pin),
    .sub_clk   (sub_clk),
    .pdn       (pdn),
    .int_en    (int_en),
    .ovf_pulse (ovf_pulse),
    .irq_req   (irq_req),
    .wake_req  (wake_req)
  );

  tec_pin_model tec_pin_model_i (
    .clk_sys (clk_sys),
    .tmr_pin (tmr_pin),
    .sub_clk (sub_clk)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{rd: 1'b0, wr: 1'b1, idx: i, wdata: d};
    @(posedge clk_sys);
    sfr_req <= '0;
  endtask : wr

  task automatic rd(input logic [1:0] i, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{rd: 1'b1, wr: 1'b0, idx: i, wdata: 8'h00};
    @(posedge clk_sys);
    sfr_req <= '0;
    #1;
    d = sfr_rdata;
  endtask : rd

  task automatic wr16(input logic [15:0] d);
    wr(TEC_IDX_CNT_LO, d[7:0]);
    wr(TEC_IDX_CNT_HI, d[15:8]);
  endtask : wr16

  task automatic rd16(output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(TEC_IDX_CNT_HI, hi);
    rd(TEC_IDX_CNT_LO, lo);
    d = {hi, lo};
  endtask : rd16

  // counts edges up to and including the one that shows the overflow
  task automatic wait_ovf(output int gap);
    gap = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      gap++;
    end
    while (ovf_pulse !== 1'b1 && gap < 2000);
    if (gap >= 2000)
    begin
      mismatches++;
      $display("FAIL %0t overflow never came", $time);
    end
  endtask : wait_ovf

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // whole run is near 1600 cycles; the 20000 cycle budget is over twelve times that
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(TEC_IDX_CTRL, b);
    chk({8'h00, b}, {8'h00, TEC_CTRL_RST});
    rd(2'h3, b);
    chk({8'h00, b}, 16'h0000);
    wr(TEC_IDX_CNT_LO, 8'h34);
    rd16(v);
    chk(v, 16'h0000);
    // the high read above refilled the buffer, so low goes in again
    wr16(16'h1234);
    rd16(v);
    chk(v, 16'h1234);
    rd(TEC_IDX_CNT_HI, b);
    wr(TEC_IDX_CNT_LO, 8'h99);
    rd(TEC_IDX_CNT_LO, b);
    chk({8'h00, b}, 16'h0099);
    // timer on system clock over four
    wr16(16'hfff0);
    @(posedge clk_sys) int_en <= 1'b1;
    wr(TEC_IDX_CTRL, 8'hb0);
    wait_ovf(g);
    chk({15'h0, irq_req}, 16'h0001);
    wait_ovf(g);
    chk(16'(g), 16'd64);
    @(posedge clk_sys) int_en <= 1'b0;
    wr16(16'hfff8);
    wait_ovf(g);
    chk(16'(g + 5), 16'd64);
    chk({14'h0, wake_req, irq_req}, 16'h0000);
    wait_ovf(g);
    chk(16'(g), 16'd32);
    wr(TEC_IDX_CTRL, 8'ha0);
    rd16(v);
    repeat (20) @(posedge clk_sys);
    rd16(w);
    chk(w, v);
    // timer on the sub clock
    wr16(16'hfff0);
    wr(TEC_IDX_CTRL, 8'h90);
    wait_ovf(g);
    wait_ovf(g);
    chk(16'(g), 16'd512);
    // event counting, prescale field set to show it is bypassed
    wr(TEC_IDX_CTRL, 8'h00);
    wr16(16'h0010);
    wr(TEC_IDX_CTRL, 8'h57);
    tec_pin_model_i.toggle(3, 8);
    rd16(v);
    chk(v, 16'h0012);
    wr(TEC_IDX_CTRL, 8'h5f);
    tec_pin_model_i.toggle(1, 8);
    rd16(v);
    chk(v, 16'h0013);
    wr(TEC_IDX_CTRL, 8'h1f);
    tec_pin_model_i.toggle(2, 8);
    rd16(v);
    chk(v, 16'h0013);
    // overflow in power-down
    wr(TEC_IDX_CTRL, 8'h00);
    wr16(16'hffff);
    @(posedge clk_sys);
    pdn    <= 1'b1;
    int_en <= 1'b1;
    wr(TEC_IDX_CTRL, 8'h57);
    tec_pin_model_i.toggle(1, 0);
    wait_ovf(g);
    chk({13'h0, ovf_pulse, wake_req, irq_req}, 16'h0007);
    @(posedge clk_sys) pdn <= 1'b0;
    // pulse width, start on falling edge
    wr(TEC_IDX_CTRL, 8'h00);
    wr16(16'h0000);
    // pin must idle high before a falling start edge
    tec_pin_model_i.toggle(2, 8);
    wr(TEC_IDX_CTRL, 8'hf0);
    repeat (40) @(posedge clk_sys);
    rd16(v);
    chk(v, 16'h0000);
    tec_pin_model_i.toggle(1, 80);
    tec_pin_model_i.toggle(1, 20);
    rd16(v);
    chk({15'h0, (v >= 16'd19) && (v <= 16'd21)}, 16'h0001);
    rd(TEC_IDX_CTRL, b);
    chk({8'h00, b}, 16'h00e0);
    tec_pin_model_i.toggle(2, 8);
    rd16(w);
    chk(w, v);
    close_out();
  end

endmodule : tb_tec_timer_event_counter
